/* rtl/vfx_alu.sv */
`timescale 1ns/100ps
// ----------------------------------------
// fixed-point element alu with apb registers
// ----------------------------------------
module vfx_alu #(
    parameter int W = 32 // element_width
) (
    input wire logic pclk, // 25 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [vfx_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    output logic sat_flag // sticky saturation
);
    // ----------------------------------------
    // sizes and checks
    // ----------------------------------------
    localparam int DW = 2 * W + 2;
    localparam int SHW = $clog2(2 * W);
    localparam int LW = $clog2(W);

    generate
        if (W != 8 && W != 16 && W != 32) begin : g_bad_width
            $error("element width must be 8, 16 or 32");
        end
    endgenerate

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } vfx_state_t;

    typedef struct packed {
        vfx_state_t st;
        logic [1:0] rm;
        logic sat;
        logic [W-1:0] a;
        logic [W-1:0] ahi;
        logic [W-1:0] b;
        logic [W-1:0] sc;
        logic [W-1:0] res;
        logic [3:0] op;
        logic [1:0] src;
        logic [vfx_pkg::IMM_W-1:0] imm;
        logic act;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } vfx_regs_t;

    vfx_regs_t q;
    vfx_regs_t d;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // extend one element to datapath width
    function automatic logic [DW-1:0] ext_elem(input logic [W-1:0] v, input logic s);
        ext_elem = {{(DW-W){s & v[W-1]}}, v};
    endfunction : ext_elem

    // address decode for the error answer; the read mux decodes paddr on its own
    function automatic logic reg_hit(input logic [vfx_pkg::ADDR_W-1:0] ad);
        case (ad)
            vfx_pkg::CTRL_OFS, vfx_pkg::STATUS_OFS, vfx_pkg::OPA_OFS,
            vfx_pkg::OPA_HI_OFS, vfx_pkg::OPB_OFS, vfx_pkg::SCALAR_OFS,
            vfx_pkg::CMD_OFS, vfx_pkg::RESULT_OFS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction : reg_hit

    // ----------------------------------------
    // operand selection
    // ----------------------------------------
    vfx_pkg::vfx_op_t op;
    logic shift_op;
    logic is_s;
    logic [W-1:0] opb;
    logic [DW-1:0] ea;
    logic [DW-1:0] eb;
    logic [2*W-1:0] wide_src;

    assign op = vfx_pkg::vfx_op_t'(q.op);
    assign shift_op = (op == vfx_pkg::OP_SSRL) || (op == vfx_pkg::OP_SSRA) ||
                      (op == vfx_pkg::OP_NCLIPU) || (op == vfx_pkg::OP_NCLIP);
    assign is_s = (op == vfx_pkg::OP_SADD) || (op == vfx_pkg::OP_SSUB) ||
                  (op == vfx_pkg::OP_AADD) || (op == vfx_pkg::OP_ASUB) ||
                  (op == vfx_pkg::OP_SMUL) || (op == vfx_pkg::OP_SSRA) ||
                  (op == vfx_pkg::OP_NCLIP);

    // second operand from vector, scalar or immediate
    always_comb begin
        case (vfx_pkg::vfx_src_t'(q.src))
            vfx_pkg::SRC_VEC: opb = q.b;
            vfx_pkg::SRC_SCALAR: opb = q.sc;
            vfx_pkg::SRC_IMM: begin
                if (shift_op) begin
                    opb = {{(W-vfx_pkg::IMM_W){1'b0}}, q.imm};
                end else begin
                    opb = {{(W-vfx_pkg::IMM_W){q.imm[vfx_pkg::IMM_W-1]}}, q.imm};
                end
            end
            default: opb = q.b;
        endcase
    end

    assign ea = ext_elem(q.a, is_s);
    assign eb = ext_elem(opb, is_s);
    assign wide_src = {q.ahi, q.a};

    // ----------------------------------------
    // rounding shifter and clipper
    // ----------------------------------------
    vfx_rnd_if #(.DW(DW), .SHW(SHW)) rnd_bus ();

    vfx_round #(.DW(DW), .SHW(SHW)) u_round (
        .rb(rnd_bus.rounder)
    );

    logic use_clip;
    logic [W-1:0] clip_res;
    logic clip_sat;

    vfx_clip #(.W(W), .DW(DW)) u_clip (
        .val(rnd_bus.res),
        .sgn(is_s),
        .res(clip_res),
        .sat(clip_sat)
    );

    // ----------------------------------------
    // per-operation datapath
    // ----------------------------------------
    logic signed [2*W-1:0] sprod;
    logic [W-1:0] dp_res;
    logic dp_sat;

    assign sprod = $signed(q.a) * $signed(opb);
    assign rnd_bus.mode = q.rm;

    always_comb begin
        rnd_bus.val = ea;
        rnd_bus.sh = '0;
        use_clip = 1'b0;
        case (op)
            vfx_pkg::OP_SADDU, vfx_pkg::OP_SADD: begin
                rnd_bus.val = ea + eb;
                use_clip = 1'b1;
            end
            vfx_pkg::OP_SSUBU, vfx_pkg::OP_SSUB: begin
                rnd_bus.val = ea - eb;
                use_clip = 1'b1;
            end
            vfx_pkg::OP_AADDU, vfx_pkg::OP_AADD: begin
                // two guard bits: sum of two elements always fits
                rnd_bus.val = ea + eb;
                rnd_bus.sh = SHW'(1);
            end
            vfx_pkg::OP_ASUBU, vfx_pkg::OP_ASUB: begin
                // max minus min under rnu/rne can exceed range; kept wrapped
                rnd_bus.val = ea - eb;
                rnd_bus.sh = SHW'(1);
            end
            vfx_pkg::OP_SMUL: begin
                rnd_bus.val = {{2{sprod[2*W-1]}}, sprod};
                rnd_bus.sh = SHW'(W - 1);
                use_clip = 1'b1;
            end
            vfx_pkg::OP_SSRL, vfx_pkg::OP_SSRA: begin
                // zero- or sign-extended by ext_elem
                rnd_bus.val = ea;
                rnd_bus.sh = {{(SHW-LW){1'b0}}, opb[LW-1:0]};
            end
            vfx_pkg::OP_NCLIPU, vfx_pkg::OP_NCLIP: begin
                rnd_bus.val = {{2{is_s & q.ahi[W-1]}}, wide_src};
                rnd_bus.sh = opb[SHW-1:0];
                use_clip = 1'b1;
            end
            default: begin
                rnd_bus.val = ea;
            end
        endcase
    end

    // clip after rounding, else keep low bits (wraps for subtract)
    always_comb begin
        if (use_clip) begin
            dp_res = clip_res;
            dp_sat = clip_sat;
        end else begin
            dp_res = rnd_bus.res[W-1:0];
            dp_sat = 1'b0;
        end
    end

    // ----------------------------------------
    // apb slave and sequencing
    // ----------------------------------------
    logic acc;
    logic wr_done;

    assign acc = psel & penable;
    assign wr_done = acc & q.rdy & pwrite;

    always_comb begin
        d = q;
        d.rdy = 1'b0;
        d.err = 1'b0;
        // one wait state: answer on the second access cycle
        if (acc && !q.rdy) begin
            d.rdy = 1'b1;
            d.err = ~reg_hit(paddr);
            d.rdata = '0;
            case (paddr)
                vfx_pkg::CTRL_OFS: d.rdata[vfx_pkg::CTRL_RM_LSB +: 2] = q.rm;
                vfx_pkg::STATUS_OFS: begin
                    d.rdata[vfx_pkg::STATUS_SAT_BIT] = q.sat;
                    d.rdata[vfx_pkg::STATUS_BUSY_BIT] = (q.st == ST_RUN);
                end
                vfx_pkg::OPA_OFS: d.rdata = 32'(q.a);
                vfx_pkg::OPA_HI_OFS: d.rdata = 32'(q.ahi);
                vfx_pkg::OPB_OFS: d.rdata = 32'(q.b);
                vfx_pkg::SCALAR_OFS: d.rdata = 32'(q.sc);
                vfx_pkg::CMD_OFS: begin
                    d.rdata[vfx_pkg::CMD_OP_LSB +: 4] = q.op;
                    d.rdata[vfx_pkg::CMD_SRC_LSB +: 2] = q.src;
                    d.rdata[vfx_pkg::CMD_IMM_LSB +: vfx_pkg::IMM_W] = q.imm;
                    d.rdata[vfx_pkg::CMD_ACT_BIT] = q.act;
                end
                vfx_pkg::RESULT_OFS: d.rdata = 32'(q.res);
                default: d.rdata = '0;
            endcase
        end
        // writes land on the edge that completes the access
        if (wr_done) begin
            case (paddr)
                vfx_pkg::CTRL_OFS: d.rm = pwdata[vfx_pkg::CTRL_RM_LSB +: 2];
                vfx_pkg::STATUS_OFS: begin
                    if (pwdata[vfx_pkg::STATUS_SAT_BIT]) begin
                        d.sat = 1'b0;
                    end
                end
                vfx_pkg::OPA_OFS: d.a = pwdata[W-1:0];
                vfx_pkg::OPA_HI_OFS: d.ahi = pwdata[W-1:0];
                vfx_pkg::OPB_OFS: d.b = pwdata[W-1:0];
                vfx_pkg::SCALAR_OFS: d.sc = pwdata[W-1:0];
                vfx_pkg::CMD_OFS: begin
                    d.op = pwdata[vfx_pkg::CMD_OP_LSB +: 4];
                    d.src = pwdata[vfx_pkg::CMD_SRC_LSB +: 2];
                    d.imm = pwdata[vfx_pkg::CMD_IMM_LSB +: vfx_pkg::IMM_W];
                    d.act = pwdata[vfx_pkg::CMD_ACT_BIT];
                    d.st = ST_RUN;
                end
                default: d.rm = q.rm;
            endcase
        end
        // one element per command
        case (q.st)
            ST_IDLE: begin
                d.st = d.st;
            end
            ST_RUN: begin
                if (q.act) begin
                    d.res = dp_res;
                    if (dp_sat) begin
                        d.sat = 1'b1;
                    end
                end
                d.st = ST_IDLE;
            end
            default: d.st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{st: ST_IDLE, rm: vfx_pkg::RM_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign sat_flag = q.sat;
endmodule : vfx_alu

/* rtl/vfx_pkg.sv */
// Notes on behaviour
// - saturating add/sub, signed and unsigned, all sources
// - overflowing add/sub clips and sets flag
// - element ranges per signedness and width
// - averaging ops halve and round discarded bit
// - averaging add sum never overflows
// - averaging subtract wraps, flag untouched
// - signed averaging subtract overflow corner only
// - fractional multiply shifts by width minus one
// - clipped fractional multiply sets flag
// - most negative squared saturates to max
// - scaling shifts round; logical zero, arithmetic sign
// - shift amount from vector, scalar, immediate
// - scaling shift uses low log2(width) bits
// - narrowing clip: shift, round, saturate double-width
// - narrowing clip uses low log2(2*width) bits
// - narrowing rounds at destination lsb first
// - unsigned narrowing clips to unsigned range
// - signed narrowing clips to signed range
// - any saturated narrowing element sets flag
package vfx_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] OPA_OFS = 8'h08;
    localparam logic [7:0] OPA_HI_OFS = 8'h0C;
    localparam logic [7:0] OPB_OFS = 8'h10;
    localparam logic [7:0] SCALAR_OFS = 8'h14;
    localparam logic [7:0] CMD_OFS = 8'h18;
    localparam logic [7:0] RESULT_OFS = 8'h1C;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CTRL_RM_LSB = 0;
    localparam int STATUS_SAT_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SRC_LSB = 4;
    localparam int CMD_IMM_LSB = 6;
    localparam int CMD_ACT_BIT = 11;
    localparam int IMM_W = 5;
    localparam logic [1:0] RM_RST = 2'h0;
    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [1:0] {RM_RNU = 2'h0, RM_RNE = 2'h1, RM_RDN = 2'h2, RM_ROD = 2'h3} vfx_rm_t;
    typedef enum logic [1:0] {SRC_VEC = 2'h0, SRC_SCALAR = 2'h1, SRC_IMM = 2'h2} vfx_src_t;
    typedef enum logic [3:0] {
        OP_SADDU = 4'h0, OP_SADD = 4'h1, OP_SSUBU = 4'h2, OP_SSUB = 4'h3,
        OP_AADDU = 4'h4, OP_AADD = 4'h5, OP_ASUBU = 4'h6, OP_ASUB = 4'h7,
        OP_SMUL = 4'h8, OP_SSRL = 4'h9, OP_SSRA = 4'hA, OP_NCLIPU = 4'hB,
        OP_NCLIP = 4'hC
    } vfx_op_t;
endpackage : vfx_pkg

/* rtl/vfx_rnd_if.sv */
`timescale 1ns/100ps
// carries one rounding shift request and its answer
interface vfx_rnd_if #(parameter int DW = 66, parameter int SHW = 6);
    logic [DW-1:0] val;
    logic [SHW-1:0] sh;
    logic [1:0] mode;
    logic [DW-1:0] res;
    modport user (output val, output sh, output mode, input res);
    modport rounder (input val, input sh, input mode, output res);
endinterface : vfx_rnd_if

/* rtl/vfx_round.sv */
`timescale 1ns/100ps
// ----------------------------------------
// right shift with rounding of the bits shifted out
// ----------------------------------------
module vfx_round #(
    parameter int DW = 66,
    parameter int SHW = 6
) (
    vfx_rnd_if.rounder rb // request and rounded result
);
    logic [DW-1:0] shifted;
    logic half;
    logic sticky;
    logic rbit;

    // value arrives pre-extended, so arithmetic shift serves both forms
    always_comb begin
        shifted = DW'($signed(rb.val) >>> rb.sh);
        half = 1'b0;
        sticky = 1'b0;
        if (rb.sh != '0) begin
            half = rb.val[rb.sh - 1'b1];
        end
        for (int i = 0; i < DW; i++) begin
            if (i + 1 < int'(rb.sh)) begin
                sticky = sticky | rb.val[i];
            end
        end
        // increment chosen by mode
        case (vfx_pkg::vfx_rm_t'(rb.mode))
            vfx_pkg::RM_RNU: rbit = half;
            vfx_pkg::RM_RNE: rbit = half & (sticky | shifted[0]);
            vfx_pkg::RM_RDN: rbit = 1'b0;
            vfx_pkg::RM_ROD: rbit = ~shifted[0] & (half | sticky);
            default: rbit = 1'b0;
        endcase
        rb.res = shifted + DW'(rbit);
    end
endmodule : vfx_round

/* rtl/vfx_clip.sv */
`timescale 1ns/100ps
// ----------------------------------------
// saturate a wide signed value into an element
// ----------------------------------------
module vfx_clip #(
    parameter int W = 32,
    parameter int DW = 66
) (
    input wire logic [DW-1:0] val, // wide two's complement value
    input wire logic sgn, // signed destination
    output logic [W-1:0] res, // clipped element
    output logic sat // value was clipped
);
    localparam logic signed [DW-1:0] SMAX = {{(DW-W+1){1'b0}}, {(W-1){1'b1}}};
    localparam logic signed [DW-1:0] SMIN = {{(DW-W+1){1'b1}}, {(W-1){1'b0}}};
    localparam logic signed [DW-1:0] UMAX = {{(DW-W){1'b0}}, {W{1'b1}}};

    // nearest representable value per range
    always_comb begin
        res = val[W-1:0];
        sat = 1'b0;
        if (sgn) begin
            if ($signed(val) > SMAX) begin
                res = SMAX[W-1:0];
                sat = 1'b1;
            end else if ($signed(val) < SMIN) begin
                res = SMIN[W-1:0];
                sat = 1'b1;
            end
        end else begin
            if ($signed(val) < 0) begin
                res = '0;
                sat = 1'b1;
            end else if ($signed(val) > UMAX) begin
                res = UMAX[W-1:0];
                sat = 1'b1;
            end
        end
    end
endmodule : vfx_clip

/* verif/vfx_alu_chk.sv */
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the element alu
// ----------------------------------------
module vfx_alu_chk #(
    parameter int W = 32 // element_width
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [vfx_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // unmapped address
    input wire logic sat_flag // sticky saturation
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic unmapped;
    logic cmd_wr;
    logic clr_wr;
    // completed transfers and address decode
    assign done = psel && penable && pready;
    assign unmapped = (paddr > vfx_pkg::RESULT_OFS) || (paddr[1:0] != 2'h0);
    assign cmd_wr = done && pwrite && paddr == vfx_pkg::CMD_OFS && pwdata[vfx_pkg::CMD_ACT_BIT];
    assign clr_wr = done && pwrite && paddr == vfx_pkg::STATUS_OFS && pwdata[vfx_pkg::STATUS_SAT_BIT];
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_wait_one: assert property (setup_s ##1 access_s |-> answer_s)
        else $error("ready not after exactly one wait state");
    chk_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside a completing access");
    chk_err_decode: assert property (done |-> pslverr == unmapped)
        else $error("error flag does not match address decode");
    chk_err_rdata: assert property (done && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    chk_result_upper: assert property (done && !pwrite && paddr == vfx_pkg::RESULT_OFS |-> (prdata >> W) == 32'h0)
        else $error("result bits above element width set");
    chk_status_mirror: assert property (done && !pwrite && paddr == vfx_pkg::STATUS_OFS |-> prdata[0] == sat_flag)
        else $error("status bit differs from flag pin");
    chk_sat_cause: assert property ($rose(sat_flag) |-> $past(cmd_wr, 2))
        else $error("flag set without an active command");
    chk_sat_sticky: assert property ($fell(sat_flag) |-> $past(clr_wr))
        else $error("flag cleared without a clearing write");
    chk_reset_quiet: assert property ($rose(presetn) |-> !pready && !pslverr && !sat_flag && prdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule : vfx_alu_chk

/* verif/vfx_seq_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// sequencer side: apb requester
// ----------------------------------------
module vfx_seq_model (
    input wire logic pclk, // clock
    output logic psel, // apb select
    output logic penable, // apb access phase
    output logic pwrite, // apb direction
    output logic [7:0] paddr, // apb byte address
    output logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr // unmapped address
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer; request held until ready is sampled
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer
endmodule : vfx_seq_model

/* verif/vfx_alu_test.sv */
`timescale 1ns/100ps
// ----------------------------------------
// self-checking bench for the element alu
// ----------------------------------------
module vfx_alu_test;
    localparam int EW = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, sat_flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [3:0][7:0] e1 = {8'h81, 8'h80, 8'h80, 8'h81};
    logic [3:0][7:0] e2 = {8'h01, 8'h01, 8'h02, 8'h02};
    vfx_seq_model seq (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    vfx_alu #(.W(EW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sat_flag(sat_flag));
    // clock and hang guard
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task wr(input logic [7:0] a, input logic [31:0] d);
        seq.apb_xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd(input logic [7:0] a);
        seq.apb_xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    // load operands, launch, compare result and flag
    task run(input logic [3:0] op, input logic [6:0] si, input logic [31:0] v, input logic [1:0] rm,
             input logic [7:0] exp, input logic sat);
        wr(vfx_pkg::CTRL_OFS, {30'h0, rm});
        wr(vfx_pkg::STATUS_OFS, 32'h1);
        wr(vfx_pkg::OPA_OFS, {24'h0, v[31:24]});
        wr(vfx_pkg::OPA_HI_OFS, {24'h0, v[23:16]});
        wr(vfx_pkg::OPB_OFS, {24'h0, v[15:8]});
        wr(vfx_pkg::SCALAR_OFS, {24'h0, v[7:0]});
        wr(vfx_pkg::CMD_OFS, {20'h0, 1'b1, si[4:0], si[6:5], op});
        rd(vfx_pkg::RESULT_OFS);
        chk_word(q, {24'h0, exp});
        rd(vfx_pkg::STATUS_OFS);
        chk_bit(q[0], sat);
        chk_bit(sat_flag, sat);
    endtask : run
    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(vfx_pkg::CTRL_OFS);
        chk_word(q, 32'h0);
        rd(vfx_pkg::STATUS_OFS);
        chk_word(q, 32'h0);
        run(vfx_pkg::OP_SADDU, 7'h00, 32'hF0002000, 2'h0, 8'hFF, 1'b1);
        wr(vfx_pkg::OPA_OFS, 32'h10);
        wr(vfx_pkg::CMD_OFS, 32'h800);
        rd(vfx_pkg::RESULT_OFS);
        chk_word(q, 32'h30);
        rd(vfx_pkg::STATUS_OFS);
        chk_bit(q[0], 1'b1);
        wr(vfx_pkg::STATUS_OFS, 32'h1);
        wr(vfx_pkg::OPA_OFS, 32'hF0);
        wr(vfx_pkg::CMD_OFS, 32'h000);
        rd(vfx_pkg::RESULT_OFS);
        chk_word(q, 32'h30);
        rd(vfx_pkg::STATUS_OFS);
        chk_bit(q[0], 1'b0);
        wr(vfx_pkg::RESULT_OFS, 32'hFFFFFFFF);
        chk_bit(e, 1'b0);
        rd(vfx_pkg::RESULT_OFS);
        chk_word(q, 32'h30);
        rd(8'h20);
        chk_word(q, 32'h0);
        chk_bit(e, 1'b1);
        wr(8'h22, 32'h1);
        chk_bit(e, 1'b1);
        run(vfx_pkg::OP_SADDU, 7'h20, 32'h10000020, 2'h0, 8'h30, 1'b0);
        run(vfx_pkg::OP_SADDU, 7'h5F, 32'h01000000, 2'h0, 8'hFF, 1'b1);
        run(vfx_pkg::OP_SADD, 7'h00, 32'h70002000, 2'h0, 8'h7F, 1'b1);
        run(vfx_pkg::OP_SADD, 7'h5F, 32'h80000000, 2'h0, 8'h80, 1'b1);
        run(vfx_pkg::OP_SSUBU, 7'h00, 32'h10002000, 2'h0, 8'h00, 1'b1);
        run(vfx_pkg::OP_SSUB, 7'h20, 32'h80000001, 2'h0, 8'h80, 1'b1);
        for (int rm = 0; rm < 4; rm++) begin
            run(vfx_pkg::OP_AADDU, 7'h00, 32'hFF000200, rm[1:0], e1[rm], 1'b0);
            run(vfx_pkg::OP_AADDU, 7'h00, 32'h03000000, rm[1:0], e2[rm], 1'b0);
        end
        run(vfx_pkg::OP_AADD, 7'h00, 32'h80008000, 2'h0, 8'h80, 1'b0);
        run(vfx_pkg::OP_ASUBU, 7'h00, 32'h00000200, 2'h2, 8'hFF, 1'b0);
        run(vfx_pkg::OP_ASUB, 7'h00, 32'h7F008000, 2'h0, 8'h80, 1'b0);
        run(vfx_pkg::OP_SMUL, 7'h00, 32'h80008000, 2'h0, 8'h7F, 1'b1);
        run(vfx_pkg::OP_SMUL, 7'h20, 32'h03000040, 2'h0, 8'h02, 1'b0);
        run(vfx_pkg::OP_SSRL, 7'h00, 32'hF4000B00, 2'h0, 8'h1F, 1'b0);
        run(vfx_pkg::OP_SSRA, 7'h20, 32'hF4000023, 2'h2, 8'hFE, 1'b0);
        run(vfx_pkg::OP_SSRL, 7'h5A, 32'h07000000, 2'h1, 8'h02, 1'b0);
        run(vfx_pkg::OP_NCLIPU, 7'h00, 32'h00011000, 2'h0, 8'hFF, 1'b1);
        run(vfx_pkg::OP_NCLIP, 7'h20, 32'hFF000001, 2'h0, 8'h7F, 1'b1);
        run(vfx_pkg::OP_NCLIP, 7'h41, 32'h00FF0000, 2'h0, 8'h80, 1'b0);
        run(vfx_pkg::OP_NCLIPU, 7'h20, 32'hFF000001, 2'h0, 8'h80, 1'b0);
        // mid-run reset: mode and sticky flag return to reset values
        wr(vfx_pkg::CTRL_OFS, 32'h3);
        wr(vfx_pkg::CMD_OFS, 32'h810);
        rd(vfx_pkg::STATUS_OFS);
        chk_bit(q[0], 1'b1);
        chk_bit(sat_flag, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(vfx_pkg::CTRL_OFS);
        chk_word(q, 32'h0);
        chk_bit(sat_flag, 1'b0);
        end_sim();
    end
endmodule : vfx_alu_test
bind vfx_alu vfx_alu_chk #(.W(W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sat_flag(sat_flag));
